// file: src/srseo_defines.svh
// constants of the system reset and enable output sequencer
`ifndef SRSEO_DEFINES_SVH
`define SRSEO_DEFINES_SVH
// ----------------------------------------------------------------
// timing
// ----------------------------------------------------------------
`define SRSEO_CLK_MHZ      125
`define SRSEO_TW0_US       20000
`define SRSEO_TW1_US       10000
`define SRSEO_TW2_US       3600
`define SRSEO_TW3_US       1000
`define SRSEO_TO_MS        256
// ----------------------------------------------------------------
// register map and fields
// ----------------------------------------------------------------
`define SRSEO_FSC_ADDR     8'h02
`define SRSEO_STARTUP_ADDR 8'h73
`define SRSEO_RLC_LSB      4
`define SRSEO_AUX_REG_STARTUP_SEL_BIT    3
`define SRSEO_FALLBACK_LSB 0
`define SRSEO_FSC_RST      8'h00
`define SRSEO_RCC_MAX      2'h3
`define SRSEO_PULSE_W      22
`define SRSEO_TO_W         26
`endif

// file: src/srseo_pkg.sv
// types shared by the reset and enable output sequencer
package srseo_pkg;
	// fail-safe control register layout
	typedef struct packed {
		logic [1:0] ext_control_battery_shutdown;
		logic       ext_control_drive_sel;
		logic [1:0] ext_control_config;
		logic       limp_home_ctrl;
		logic [1:0] reset_event_counter;
	} srseo_fsc_t;

	// reset sources and qualifiers from the rest of the chip
	typedef struct packed {
		logic main_uv;
		logic wd_win_overflow;
		logic wd_win_early;
		logic wd_to_overflow;
		logic watchdog_overflow_irq;
		logic wd_ctrl_write;
		logic leave_off;
		logic leave_overload;
		logic sleep_wake;
		logic sleep_cmd;
		logic no_regular_irq_sel;
	} srseo_src_t;

	typedef enum logic [2:0] {
		st_reset,
		st_pulse,
		st_standby,
		st_normal,
		st_fail_safe
	} srseo_state_t;
endpackage

// file: src/srseo_top.sv
// reset sequencer with reset line and enable output drivers
`include "srseo_defines.svh"
`timescale 1ns/1ps
`default_nettype none

module srseo_top #(
	parameter int unsigned TW0_CYC = `SRSEO_TW0_US * `SRSEO_CLK_MHZ,
	parameter int unsigned TW1_CYC = `SRSEO_TW1_US * `SRSEO_CLK_MHZ,
	parameter int unsigned TW2_CYC = `SRSEO_TW2_US * `SRSEO_CLK_MHZ,
	parameter int unsigned TW3_CYC = `SRSEO_TW3_US * `SRSEO_CLK_MHZ,
	parameter int unsigned TO_CYC  = `SRSEO_TO_MS * 1000 * `SRSEO_CLK_MHZ
) (
	input  wire logic                      mclk,
	input  wire logic                      rst,
	input  wire srseo_pkg::srseo_src_t     src,
	input  wire logic                      host_irq_n,
	input  wire logic                      battery_uv,
	input  wire logic                      battery_ov,
	input  wire logic                      go_normal,
	input  wire logic                      timer2_out,
	input  wire logic [7:0]                startup_configuration,
	input  wire logic                      fsc_wr,
	input  wire srseo_pkg::srseo_fsc_t     fsc_wdata,
	input  wire logic                      reset_line_n_i,
	output var  logic                      reset_line_n_o,
	output var  logic                      reset_line_n_oe,
	output var  logic                      ext_control_o,
	output var  logic                      ext_control_oe,
	output var  srseo_pkg::srseo_fsc_t     fail_safe_control,
	output var  srseo_pkg::srseo_state_t   sbc_state,
	output var  logic                      fail_safe_state,
	output var  logic [1:0]                aux_reg_control,
	output var  logic [2:0]                pin_fallback_sel
);
	import srseo_pkg::*;

	localparam int PW = `SRSEO_PULSE_W;
	localparam int TW = `SRSEO_TO_W;

	srseo_state_t         next_state;
	srseo_fsc_t           next_fsc;
	logic [PW-1:0]        pulse_cnt;
	logic [PW-1:0]        next_pulse_cnt;
	logic [PW-1:0]        width_cyc;
	logic [TW-1:0]        to_cnt;
	logic [TW-1:0]        next_to_cnt;
	logic                 cold;
	logic                 next_cold;
	logic                 drv_q;
	logic                 ext_low;
	logic                 cold_src;
	logic                 warm_src;
	logic                 loaded;
	logic [1:0]           rcc_inc;
	logic [1:0]           reset_pulse_length_sel;
	logic                 en_level;
	logic                 next_en_o;
	logic                 next_en_oe;

	// ----------------------------------------------------------------
	// reset sources
	// ----------------------------------------------------------------
	// own drive and the cycle after it are masked: the pull-up
	// needs a cycle to lift the line after release
	assign ext_low = !reset_line_n_i && !reset_line_n_oe && !drv_q;
	assign cold_src = src.main_uv || src.leave_off
		|| src.leave_overload || src.sleep_wake;
	assign warm_src = ext_low
		|| src.wd_win_overflow || src.wd_win_early
		|| (src.wd_to_overflow && src.watchdog_overflow_irq)
		|| (src.wd_ctrl_write && sbc_state == st_normal)
		|| src.leave_off || src.leave_overload || src.sleep_wake
		|| (src.sleep_cmd && (!host_irq_n
			|| src.no_regular_irq_sel));
	assign rcc_inc = (fail_safe_control.reset_event_counter
		== `SRSEO_RCC_MAX) ? `SRSEO_RCC_MAX
		: fail_safe_control.reset_event_counter + 2'h1;
	assign reset_pulse_length_sel =
		startup_configuration[`SRSEO_RLC_LSB +: 2];

	// pulse width: warm starts always take the shortest one
	always_comb begin
		case (cold ? reset_pulse_length_sel : 2'b11)
			2'b00:   width_cyc = PW'(TW0_CYC);
			2'b01:   width_cyc = PW'(TW1_CYC);
			2'b10:   width_cyc = PW'(TW2_CYC);
			default: width_cyc = PW'(TW3_CYC);
		endcase
	end

	// ----------------------------------------------------------------
	// sequencer
	// ----------------------------------------------------------------
	// hardware updates of the counter and limp bit override a host
	// write in the same cycle, so no event is lost
	always_comb begin
		next_state = sbc_state;
		next_fsc = fsc_wr ? fsc_wdata : fail_safe_control;
		next_pulse_cnt = pulse_cnt + PW'(1);
		next_to_cnt = to_cnt;
		next_cold = cold;
		case (sbc_state)
			st_reset: begin
				next_pulse_cnt = '0;
				next_to_cnt = to_cnt + TW'(1);
				if (fail_safe_control.reset_event_counter
					== `SRSEO_RCC_MAX) begin
					next_state = st_fail_safe;
					next_fsc.limp_home_ctrl = 1'b1;
				end else begin
					if (!battery_uv) begin
						next_fsc.reset_event_counter = rcc_inc;
					end
					next_state = st_pulse;
				end
			end
			st_pulse: begin
				next_to_cnt = to_cnt + TW'(1);
				if (warm_src) begin
					next_state = st_reset;
					next_cold = cold_src;
				end else if (to_cnt >= TW'(TO_CYC - 1)) begin
					// ahead of undervoltage: a held low supply must not
					// hold off the time-out forever
					next_fsc.reset_event_counter = rcc_inc;
					next_to_cnt = '0;
					next_pulse_cnt = '0;
					if (rcc_inc == `SRSEO_RCC_MAX) begin
						next_state = st_fail_safe;
						next_fsc.limp_home_ctrl = 1'b1;
					end
				end else if (src.main_uv) begin
					next_pulse_cnt = '0;
					next_cold = 1'b1;
				end else if (pulse_cnt >= width_cyc - PW'(1)) begin
					next_state = st_standby;
					next_to_cnt = '0;
				end
			end
			st_standby, st_normal: begin
				next_pulse_cnt = '0;
				if (warm_src || src.main_uv) begin
					next_state = st_reset;
					next_cold = cold_src;
				end else if (sbc_state == st_standby && go_normal) begin
					next_state = st_normal;
				end
			end
			st_fail_safe: begin
				// held until a chip reset: only the limp bit is forced, a host write can still change the counter
				next_pulse_cnt = '0;
				next_fsc.limp_home_ctrl = 1'b1;
			end
			default: begin
				next_state = st_reset;
			end
		endcase
	end

	always_ff @(posedge mclk) begin
		if (rst) begin
			sbc_state <= st_reset;
			fail_safe_control <= `SRSEO_FSC_RST;
			pulse_cnt <= '0;
			to_cnt <= '0;
			cold <= 1'b1;
		end else begin
			sbc_state <= next_state;
			fail_safe_control <= next_fsc;
			pulse_cnt <= next_pulse_cnt;
			to_cnt <= next_to_cnt;
			cold <= next_cold;
		end
	end

	// ----------------------------------------------------------------
	// pin drivers
	// ----------------------------------------------------------------
	// enable level from mode and configuration, battery fault wins in normal only
	always_comb begin
		case (fail_safe_control.ext_control_config)
			2'b00:   en_level = 1'b0;
			2'b01:   en_level = sbc_state inside
				{st_reset, st_pulse, st_standby, st_normal};
			2'b10:   en_level = sbc_state == st_normal;
			default: en_level = timer2_out;
		endcase
		if (sbc_state == st_normal
			&& ((fail_safe_control.ext_control_battery_shutdown[0]
				&& battery_uv)
			|| (fail_safe_control.ext_control_battery_shutdown[1]
				&& battery_ov))) begin
			en_level = 1'b0;
		end
		next_en_o = en_level;
		// open-drain releases instead of driving high
		next_en_oe = !(fail_safe_control.ext_control_drive_sel
			&& en_level);
	end

	// aux and fallback start-up fields are taken once, at the first edge after reset; the pulse length field is read live
	always_ff @(posedge mclk) begin
		if (rst) begin
			reset_line_n_o <= 1'b1;
			reset_line_n_oe <= 1'b0;
			drv_q <= 1'b0;
			ext_control_o <= 1'b0;
			ext_control_oe <= 1'b1;
			fail_safe_state <= 1'b0;
			loaded <= 1'b0;
			aux_reg_control <= 2'b00;
			pin_fallback_sel <= 3'b000;
		end else begin
			reset_line_n_o <= next_state != st_pulse;
			reset_line_n_oe <= next_state == st_pulse;
			drv_q <= reset_line_n_oe;
			ext_control_o <= next_en_o;
			ext_control_oe <= next_en_oe;
			fail_safe_state <= next_state == st_fail_safe;
			loaded <= 1'b1;
			if (!loaded) begin
				aux_reg_control <= {2{
					startup_configuration[`SRSEO_AUX_REG_STARTUP_SEL_BIT]}};
				pin_fallback_sel <= startup_configuration[
					`SRSEO_FALLBACK_LSB +: 3];
			end
		end
	end

	// ----------------------------------------------------------------
	// assertions
	// ----------------------------------------------------------------
	default clocking cb @(posedge mclk); endclocking
	default disable iff (rst);

	a_fail_entry: assert property (sbc_state == st_reset
		&& fail_safe_control.reset_event_counter == 2'h3
		|=> sbc_state == st_fail_safe && fail_safe_state)
		else $error("full counter did not reach fail-safe");
	a_count_incr: assert property (sbc_state == st_reset
		&& fail_safe_control.reset_event_counter < 2'h3 && !battery_uv
		|=> fail_safe_control.reset_event_counter
		== $past(fail_safe_control.reset_event_counter) + 2'h1)
		else $error("counter not incremented on reset entry");
	a_count_lowbat: assert property (sbc_state == st_reset
		&& battery_uv && !fsc_wr
		|=> $stable(fail_safe_control.reset_event_counter))
		else $error("counter moved under battery undervoltage");
	a_pulse_drive: assert property (sbc_state == st_pulse
		|-> reset_line_n_oe && !reset_line_n_o)
		else $error("reset line not driven low during pulse");
	a_pulse_len: assert property (sbc_state == st_pulse
		&& next_state == st_standby
		|-> pulse_cnt == width_cyc - PW'(1)
		##1 !reset_line_n_oe)
		else $error("pulse ended at wrong count");
	a_uv_restart: assert property (sbc_state == st_pulse
		&& src.main_uv && !warm_src && to_cnt < TW'(TO_CYC - 1)
		|=> pulse_cnt == '0 && sbc_state == st_pulse)
		else $error("undervoltage did not restart pulse timer");
	a_to_fail: assert property (sbc_state == st_pulse && !warm_src
		&& to_cnt >= TW'(TO_CYC - 1)
		&& fail_safe_control.reset_event_counter == 2'h2
		|=> sbc_state == st_fail_safe)
		else $error("time-out at counter two did not fail");
	a_warm_short: assert property (!cold
		|-> width_cyc == PW'(TW3_CYC))
		else $error("warm start not using shortest width");
	a_ext_sense: assert property (sbc_state == st_standby
		&& !reset_line_n_i && !reset_line_n_oe && !drv_q
		|=> sbc_state == st_reset ##1 reset_line_n_oe)
		else $error("external low not taken as reset");
	a_en_fault: assert property (sbc_state == st_normal
		&& fail_safe_control.ext_control_battery_shutdown[0]
		&& battery_uv |=> !ext_control_o && ext_control_oe)
		else $error("battery fault did not force enable low");
	a_en_off: assert property (fail_safe_control.ext_control_config
		== 2'b00 |=> !ext_control_o)
		else $error("enable high while configured low");

	c_pulse_done: cover property (sbc_state == st_pulse
		##1 sbc_state == st_standby);
	c_fail_safe: cover property (sbc_state == st_reset
		##1 sbc_state == st_fail_safe);
	c_timeout: cover property (sbc_state == st_pulse
		&& to_cnt >= TW'(TO_CYC - 1));
	c_normal: cover property (sbc_state == st_normal);
endmodule

`default_nettype wire

// file: sim/srseo_host_model.sv
// host side of the reset line: wire resolution and pulse timing
`timescale 1ns/1ps
`default_nettype none
module srseo_host_model #(
	parameter int unsigned HOLD_CYC = 8
) (
	input  wire logic        mclk,
	input  wire logic        dev_o,
	input  wire logic        dev_oe,
	input  wire logic        pull_req,
	output wire logic        line_n,
	output var  int unsigned low_len
);
	int unsigned hold = 0;
	int unsigned cnt  = 0;
	// pull-up wins unless a party sinks the line
	assign line_n = !(dev_oe && !dev_o) && hold == 0;
	// host sinks at least one shortest pulse width
	always @(posedge mclk) begin
		if (pull_req)
			hold <= HOLD_CYC;
		else if (hold != 0)
			hold <= hold - 1;
		cnt <= dev_oe ? cnt + 1 : 0;
		if (!dev_oe && cnt != 0)
			low_len <= cnt; // device sink length, in cycles
	end
endmodule
`default_nettype wire

// file: sim/tb.sv
// self-checking bench of the reset and enable sequencer
`timescale 1ns/1ps
`default_nettype none
module tb;
	import srseo_pkg::*;
	typedef struct {
		logic        cold;
		logic [7:0]  su;
		logic        buv;
		logic [10:0] s;
		logic [7:0]  len;
		logic [1:0]  cnt;
	} srseo_row_t;
	logic         mclk       = 0;
	logic         rst        = 1;
	srseo_src_t   src        = '0;
	logic         battery_uv = 0;
	logic         battery_ov = 0;
	logic         host_irq_n = 1;
	logic         go_normal  = 0;
	logic         timer2_out = 1;
	logic [7:0]   startup    = '0;
	logic         fsc_wr     = 0;
	srseo_fsc_t   fsc_wdata  = '0;
	logic         pull_req   = 0;
	wire logic    line_n;
	logic         rl_o, rl_oe, en_o, en_oe, fss;
	srseo_fsc_t   fsc;
	srseo_state_t state;
	logic [1:0]   aux;
	logic [2:0]   fb;
	int unsigned  low_len;
	int           bad_count  = 0;
	int           n_compared = 0;
	// cold rows first (last one fixes width 12), then warm/cold sources
	srseo_row_t rows[13] = '{
		'{1'b1, 8'h00, 1'b0, 11'h000, 8'h14, 2'h1},
		'{1'b1, 8'h1F, 1'b0, 11'h000, 8'h10, 2'h1},
		'{1'b1, 8'h3A, 1'b0, 11'h000, 8'h08, 2'h1},
		'{1'b1, 8'h25, 1'b1, 11'h000, 8'h0C, 2'h0},
		'{1'b0, 8'h25, 1'b0, 11'h400, 8'h0C, 2'h1},
		'{1'b0, 8'h25, 1'b0, 11'h200, 8'h08, 2'h1},
		'{1'b0, 8'h25, 1'b0, 11'h100, 8'h08, 2'h1},
		'{1'b0, 8'h25, 1'b0, 11'h0C0, 8'h08, 2'h1},
		'{1'b0, 8'h25, 1'b0, 11'h020, 8'h08, 2'h1},
		'{1'b0, 8'h25, 1'b0, 11'h010, 8'h0C, 2'h1},
		'{1'b0, 8'h25, 1'b0, 11'h008, 8'h0C, 2'h1},
		'{1'b0, 8'h25, 1'b0, 11'h004, 8'h0C, 2'h1},
		'{1'b0, 8'h25, 1'b0, 11'h003, 8'h08, 2'h1}};

	// short widths keep the run brief; time-out stays above them
	srseo_top #(.TW0_CYC(20), .TW1_CYC(16), .TW2_CYC(12), .TW3_CYC(8),
		.TO_CYC(200)) i_srseo_top (
		.mclk(mclk), .rst(rst), .src(src), .host_irq_n(host_irq_n),
		.battery_uv(battery_uv), .battery_ov(battery_ov),
		.go_normal(go_normal), .timer2_out(timer2_out),
		.startup_configuration(startup), .fsc_wr(fsc_wr),
		.fsc_wdata(fsc_wdata), .reset_line_n_i(line_n),
		.reset_line_n_o(rl_o), .reset_line_n_oe(rl_oe),
		.ext_control_o(en_o), .ext_control_oe(en_oe),
		.fail_safe_control(fsc), .sbc_state(state),
		.fail_safe_state(fss), .aux_reg_control(aux),
		.pin_fallback_sel(fb));
	srseo_host_model i_srseo_host_model (.mclk(mclk), .dev_o(rl_o),
		.dev_oe(rl_oe), .pull_req(pull_req), .line_n(line_n),
		.low_len(low_len));

	// 125 MHz clock
	initial begin
		forever #4 mclk = ~mclk;
	end

	// ----
	// tasks
	// ----
	task automatic tick;
		@(posedge mclk);
		#1;
	endtask
	task automatic check(input logic [31:0] seen, exp, input string m);
		n_compared++;
		if (seen !== exp) begin
			bad_count++;
			$display("unexpected at %0t: %s seen %0h want %0h",
				$time, m, seen, exp);
		end
	endtask
	task automatic wr(input logic [7:0] v);
		fsc_wdata = v;
		fsc_wr = 1;
		tick;
		fsc_wr = 0;
		tick;
	endtask
	task automatic to_normal;
		go_normal = 1;
		tick;
		go_normal = 0;
		tick;
	endtask
	task automatic apply_reset(input logic [7:0] su);
		startup = su;
		rst = 1;
		repeat (3) tick;
		rst = 0;
	endtask
	// bounded wait for one whole sink pulse on the line
	task automatic wait_pulse;
		int n;
		n = 0;
		while (rl_oe !== 1'b1 && n < 400) begin
			tick;
			n++;
		end
		while (rl_oe === 1'b1 && n < 400) begin
			tick;
			n++;
		end
		tick;
	endtask
	task automatic run_row(input srseo_row_t r);
		battery_uv = r.buv;
		if (r.cold) begin
			apply_reset(r.su);
		end else begin
			wr(8'h00);
			to_normal;
			src = srseo_src_t'(r.s);
			tick;
			src = '0;
		end
		wait_pulse;
		check(low_len, r.len, "width");
		check(fsc.reset_event_counter, r.cnt, "count");
		check(state, st_standby, "state");
		if (r.cold) begin
			check(aux, r.su[3] ? 2'h3 : 2'h0, "aux");
			check(fb, r.su[2:0], "fallback");
		end
		$display("row done at %0t", $time);
	endtask
	task automatic finish_test;
		$display("compared %0d mismatched %0d", n_compared, bad_count);
		if (bad_count == 0 && n_compared > 0)
			$display("TEST PASSED");
		else
			$display("TEST FAILED");
		$finish;
	endtask

	// watchdog: whole run needs under a thousand of the 12500 cycles allowed
	initial begin
		#100us;
		bad_count++;
		$display("unexpected at %0t: run hung", $time);
		finish_test;
	end

	// main sequence
	initial begin
		foreach (rows[i]) begin
			run_row(rows[i]);
		end
		// external sink on the line from standby
		wr(8'h00);
		pull_req = 1;
		tick;
		pull_req = 0;
		wait_pulse;
		check(low_len, 8'h08, "ext width");
		check(fsc.reset_event_counter, 2'h1, "ext count");
		$display("external reset done");
		// refused sources in standby, then a sleep command with irq low
		src = srseo_src_t'(11'h0A2);
		tick;
		src = '0;
		repeat (2) tick;
		check(state, st_standby, "refused");
		host_irq_n = 0;
		src = srseo_src_t'(11'h002);
		tick;
		src = '0;
		host_irq_n = 1;
		wait_pulse;
		check(low_len, 8'h08, "sleep width");
		check(fsc.reset_event_counter, 2'h2, "sleep count");
		$display("sleep reset done");
		// enable output modes in normal, then battery shutdown
		to_normal;
		for (int i = 0; i < 4; i++) begin
			wr(8'h40 | 8'(i << 3));
			tick;
			check(en_o, i != 0, "enable");
			check(en_oe, 1'b1, "enable drive");
		end
		battery_uv = 1;
		repeat (2) tick;
		check(en_o, 1'b0, "shutdown");
		battery_uv = 0;
		// timer two really steers the pin, not just a high level
		timer2_out = 0;
		repeat (2) tick;
		check(en_o, 1'b0, "timer two");
		timer2_out = 1;
		// overvoltage-only shutdown ignores undervoltage
		wr(8'h98);
		battery_uv = 1;
		repeat (2) tick;
		check(en_o, 1'b1, "uv ignored");
		battery_ov = 1;
		repeat (2) tick;
		check(en_o, 1'b0, "ov shutdown");
		battery_uv = 0;
		battery_ov = 0;
		wr(8'h28);
		tick;
		check(en_oe, 1'b0, "open drain");
		$display("enable done");
		// saturated counter diverts to fail-safe
		wr(8'h03);
		src = srseo_src_t'(11'h200);
		tick;
		src = '0;
		repeat (4) tick;
		check(state, st_fail_safe, "fail-safe");
		check({fss, fsc.limp_home_ctrl, rl_oe}, 3'h6, "limp");
		$display("fail-safe done");
		// held main undervoltage: pulse restarts until time-outs
		apply_reset(8'h00);
		src = srseo_src_t'(11'h400);
		repeat (100) tick;
		check({state, rl_oe}, {st_pulse, 1'b1}, "restart");
		repeat (400) tick;
		check(state, st_fail_safe, "time-out");
		check(fsc.reset_event_counter, 2'h3, "to count");
		src = '0;
		$display("time-out done");
		finish_test;
	end
endmodule
`default_nettype wire
